/* File: common/hs_switch_defs.vh */
// constants for the high-side switch control block
// assumes a 25 MHz aclk and an AXI4-Lite register bus
`ifndef HS_SWITCH_DEFS_VH
`define HS_SWITCH_DEFS_VH
// register word indices, the byte address is four times the index
`define OFS_CTRL_A      4'h0
`define OFS_CTRL_B      4'h1
`define OFS_SUPPLY_CFG  4'h2
`define OFS_DUTY_A      4'h3
`define OFS_DUTY_B      4'h4
`define OFS_FREQ        4'h5
`define OFS_OC_STAT     4'h6
`define OFS_OL_STAT     4'h7
`define OFS_SUPPLY_STAT 4'h8
`define OFS_MODE        4'h9
// output source codes
`define SRC_OFF    3'h0
`define SRC_ON     3'h1
`define SRC_TMR1   3'h2
`define SRC_TMR2   3'h3
`define SRC_PWM1   3'h4
`define SRC_PWM2   3'h5
// chip modes
`define MODE_NORMAL   3'h0
`define MODE_STOP     3'h1
`define MODE_SLEEP    3'h2
`define MODE_RESTART  3'h3
`define MODE_FAILSAFE 3'h4
// timing
`define CLK_HZ         25000000
`define OC_FILTER_NS   16000
`define OC_FILTER_CYC  ((`OC_FILTER_NS * 25 + 999) / 1000)
`define OL_FILTER_NS   64000
`define OL_FILTER_CYC  ((`OL_FILTER_NS * 25 + 999) / 1000)
`define PWM_HZ_SLOW    200
`define PWM_HZ_FAST    400
`define PWM_STEP_SLOW  (`CLK_HZ / (`PWM_HZ_SLOW * 256))
`define PWM_STEP_FAST  (`CLK_HZ / (`PWM_HZ_FAST * 256))
// axi responses
`define RESP_OKAY   2'h0
`define RESP_SLVERR 2'h2
`endif

/* File: src/high_side_switch_control.v */
// four high-side outputs with direct, timer and pwm sources, supply and load protection
// assumes synchronous comparator inputs from the analog front end
`timescale 1ns/10ps
`include "hs_switch_defs.vh"
module high_side_switch_control
#(
  parameter OC_CYC = `OC_FILTER_CYC,
  parameter OL_CYC = `OL_FILTER_CYC
)
(
  // clock and reset
  input  wire        aclk,
  input  wire        aresetn,
  // axi4-lite write
  input  wire [5:0]  s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output reg         s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output reg         s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  // axi4-lite read
  input  wire [5:0]  s_axi_araddr,
  input  wire        s_axi_arvalid,
  output reg         s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  // analog comparators, chip state and timers
  input  wire        supply_ov,
  input  wire        supply_uv,
  input  wire [3:0]  over_current,
  input  wire [3:0]  under_current,
  input  wire [2:0]  chip_mode,
  input  wire        timer1_out,
  input  wire        timer2_out,
  // switch gates
  output reg  [3:0]  high_side_output
);

  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  reg [11:0] src_r;
  reg [2:0]  supply_cfg_r;
  reg [7:0]  duty_a_r;
  reg [7:0]  duty_b_r;
  reg [1:0]  freq_r;
  reg [3:0]  oc_flag_r;
  reg [3:0]  ol_flag_r;
  reg [1:0]  supply_flag_r;
  reg [15:0] oc_cnt_r [0:3];
  reg [15:0] ol_cnt_r [0:3];
  reg [7:0]  pwm_cnt_r [0:1];
  reg [15:0] pwm_pre_r [0:1];
  reg [1:0]  pwm_out_r;
  reg        fault_d_r;
  reg        aw_held_r;
  reg        w_held_r;
  reg [5:0]  awaddr_r;
  reg [31:0] wdata_r;
  reg [3:0]  wstrb_r;

  // filter limits and one duty count's length minus one, cut to counter width
  localparam integer OC_I      = OC_CYC;
  localparam integer OL_I      = OL_CYC;
  localparam integer FAST_I    = `PWM_STEP_FAST - 1;
  localparam integer SLOW_I    = `PWM_STEP_SLOW - 1;
  localparam [15:0]  OC_LIM    = OC_I[15:0];
  localparam [15:0]  OL_LIM    = OL_I[15:0];
  localparam [15:0]  STEP_FAST = FAST_I[15:0];
  localparam [15:0]  STEP_SLOW = SLOW_I[15:0];

  wire ov_dis   = supply_cfg_r[0];
  wire uv_dis   = supply_cfg_r[1];
  wire recover  = supply_cfg_r[2];
  wire ov_act   = supply_ov & ~ov_dis;
  wire uv_act   = supply_uv & ~uv_dis;
  wire fault    = ov_act | uv_act;
  wire locked   = (chip_mode == `MODE_STOP) || (chip_mode == `MODE_SLEEP);
  wire kill     = (chip_mode == `MODE_RESTART) || (chip_mode == `MODE_FAILSAFE);

  // ------------------------------------------------------------
  // source selection
  // ------------------------------------------------------------
  function sel_src;
    input [2:0] code;
    input       t1;
    input       t2;
    input [1:0] pw;
    begin
      case (code)
        `SRC_ON:   sel_src = 1'b1;
        `SRC_TMR1: sel_src = t1;
        `SRC_TMR2: sel_src = t2;
        `SRC_PWM1: sel_src = pw[0];
        `SRC_PWM2: sel_src = pw[1];
        default:   sel_src = 1'b0;
      endcase
    end
  endfunction

  // ------------------------------------------------------------
  // pwm generators
  // ------------------------------------------------------------
  // counters free-run so an assignment takes effect at once
  integer    j;
  always @(posedge aclk)
  begin
    for (j = 0; j < 2; j = j + 1)
    begin
      if (!aresetn)
      begin
        pwm_pre_r[j] <= 16'h0000;
        pwm_cnt_r[j] <= 8'h00;
        pwm_out_r[j] <= 1'b0;
      end
      else
      begin
        if (pwm_pre_r[j] >= (freq_r[j] ? STEP_FAST : STEP_SLOW))
        begin
          pwm_pre_r[j] <= 16'h0000;
          pwm_cnt_r[j] <= pwm_cnt_r[j] + 8'h01;
        end
        else
          pwm_pre_r[j] <= pwm_pre_r[j] + 16'h0001;
        pwm_out_r[j] <= (pwm_cnt_r[j] < ((j == 0) ? duty_a_r : duty_b_r));
      end
    end
  end

  // ------------------------------------------------------------
  // output drive and protection
  // ------------------------------------------------------------
  reg [3:0]  want;
  reg [3:0]  oc_trip;
  integer    i;
  integer    k;
  integer    m;
  always @*
  begin
    for (i = 0; i < 4; i = i + 1)
    begin
      want[i] = sel_src(src_r[3*i +: 3], timer1_out, timer2_out, pwm_out_r);
      oc_trip[i] = high_side_output[i] && over_current[i] && (oc_cnt_r[i] >= OC_LIM);
    end
  end

  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      high_side_output <= 4'h0;
      fault_d_r        <= 1'b0;
      for (k = 0; k < 4; k = k + 1)
      begin
        oc_cnt_r[k] <= 16'h0000;
        ol_cnt_r[k] <= 16'h0000;
      end
    end
    else
    begin
      fault_d_r <= fault;
      high_side_output <= (kill || fault) ? 4'h0 : (want & ~oc_trip);
      for (k = 0; k < 4; k = k + 1)
      begin
        if (high_side_output[k] && over_current[k] && oc_cnt_r[k] < OC_LIM)
          oc_cnt_r[k] <= oc_cnt_r[k] + 16'h0001;
        else if (!over_current[k] || !high_side_output[k])
          oc_cnt_r[k] <= 16'h0000;
        if (high_side_output[k] && under_current[k] && ol_cnt_r[k] < OL_LIM)
          ol_cnt_r[k] <= ol_cnt_r[k] + 16'h0001;
        else if (!under_current[k] || !high_side_output[k])
          ol_cnt_r[k] <= 16'h0000;
      end
    end
  end

  // ------------------------------------------------------------
  // axi4-lite write path and register updates
  // ------------------------------------------------------------
  wire        wr_go  = aw_held_r && w_held_r && !s_axi_bvalid;
  wire [3:0]  wr_idx = awaddr_r[5:2];
  wire        wr_ok  = (wr_idx <= `OFS_MODE) && wr_idx != `OFS_MODE && wr_idx != `OFS_SUPPLY_STAT;
  wire        cfg_wr = wr_go && !locked && wstrb_r[0];
  wire [3:0]  ol_hit;
  assign ol_hit[0] = (ol_cnt_r[0] >= OL_LIM);
  assign ol_hit[1] = (ol_cnt_r[1] >= OL_LIM);
  assign ol_hit[2] = (ol_cnt_r[2] >= OL_LIM);
  assign ol_hit[3] = (ol_cnt_r[3] >= OL_LIM);

  reg [11:0] src_nxt;
  always @*
  begin
    src_nxt = src_r;
    if (cfg_wr && wr_idx == `OFS_CTRL_A)
      src_nxt[5:0] = wdata_r[5:0];
    if (cfg_wr && wr_idx == `OFS_CTRL_B)
      src_nxt[11:6] = wdata_r[5:0];
    for (m = 0; m < 4; m = m + 1)
      if (oc_trip[m])
        src_nxt[3*m +: 3] = `SRC_OFF;
    if (fault && !fault_d_r && !recover)
      src_nxt = 12'h000;
  end

  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `RESP_OKAY;
      aw_held_r     <= 1'b0;
      w_held_r      <= 1'b0;
      awaddr_r      <= 6'h00;
      wdata_r       <= 32'h00000000;
      wstrb_r       <= 4'h0;
      src_r         <= 12'h000;
      supply_cfg_r  <= 3'h0;
      duty_a_r      <= 8'h00;
      duty_b_r      <= 8'h00;
      freq_r        <= 2'h0;
      oc_flag_r     <= 4'h0;
      ol_flag_r     <= 4'h0;
      supply_flag_r <= 2'h0;
    end
    else
    begin
      s_axi_awready <= !aw_held_r && s_axi_awvalid && !s_axi_awready;
      s_axi_wready  <= !w_held_r && s_axi_wvalid && !s_axi_wready;
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_held_r <= 1'b1;
        awaddr_r  <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_held_r <= 1'b1;
        wdata_r  <= s_axi_wdata;
        wstrb_r  <= s_axi_wstrb;
      end
      if (wr_go)
      begin
        aw_held_r    <= 1'b0;
        w_held_r     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_ok ? `RESP_OKAY : `RESP_SLVERR;
      end
      else if (s_axi_bvalid && s_axi_bready)
        s_axi_bvalid <= 1'b0;
      src_r <= src_nxt;
      if (cfg_wr && wr_idx == `OFS_SUPPLY_CFG)
        supply_cfg_r <= wdata_r[2:0];
      if (cfg_wr && wr_idx == `OFS_DUTY_A)
        duty_a_r <= wdata_r[7:0];
      if (cfg_wr && wr_idx == `OFS_DUTY_B)
        duty_b_r <= wdata_r[7:0];
      if (cfg_wr && wr_idx == `OFS_FREQ)
        freq_r <= wdata_r[1:0];
      // set wins over write-one-to-clear
      oc_flag_r <= (oc_flag_r & ~((wr_go && wstrb_r[0] && wr_idx == `OFS_OC_STAT)
                   ? wdata_r[3:0] : 4'h0)) | oc_trip;
      ol_flag_r <= (ol_flag_r & ~((wr_go && wstrb_r[0] && wr_idx == `OFS_OL_STAT)
                   ? wdata_r[3:0] : 4'h0)) | ol_hit;
      supply_flag_r <= {supply_uv, supply_ov};
    end
  end

  // ------------------------------------------------------------
  // axi4-lite read path
  // ------------------------------------------------------------
  reg [31:0] rd_val;
  reg        rd_ok;
  always @*
  begin
    rd_ok = 1'b1;
    case (s_axi_araddr[5:2])
      `OFS_CTRL_A:      rd_val = {26'h0, src_r[5:0]};
      `OFS_CTRL_B:      rd_val = {26'h0, src_r[11:6]};
      `OFS_SUPPLY_CFG:  rd_val = {29'h0, supply_cfg_r};
      `OFS_DUTY_A:      rd_val = {24'h0, duty_a_r};
      `OFS_DUTY_B:      rd_val = {24'h0, duty_b_r};
      `OFS_FREQ:        rd_val = {30'h0, freq_r};
      `OFS_OC_STAT:     rd_val = {28'h0, oc_flag_r};
      `OFS_OL_STAT:     rd_val = {28'h0, ol_flag_r};
      `OFS_SUPPLY_STAT: rd_val = {30'h0, supply_flag_r};
      `OFS_MODE:        rd_val = {25'h0, high_side_output, chip_mode};
      default:
      begin
        rd_val = 32'h00000000;
        rd_ok  = 1'b0;
      end
    endcase
  end

  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h00000000;
      s_axi_rresp   <= `RESP_OKAY;
    end
    else
    begin
      s_axi_arready <= s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
      if (s_axi_arvalid && s_axi_arready)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= rd_val;
        s_axi_rresp  <= rd_ok ? `RESP_OKAY : `RESP_SLVERR;
      end
      else if (s_axi_rvalid && s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
  end

endmodule

/* File: tb/hs_switch_monitor.sv */
// port-level checks for the high-side switch block
// assumes it is bound to the block and sees its ports only
`timescale 1ns/10ps
module hs_switch_monitor
(
  // clock and reset
  input wire       aclk,
  input wire       aresetn,
  // bus handshakes
  input wire       s_axi_awready,
  input wire       s_axi_bvalid,
  input wire       s_axi_bready,
  input wire       s_axi_arvalid,
  input wire       s_axi_arready,
  input wire       s_axi_rvalid,
  input wire       s_axi_rready,
  // load side and chip mode
  input wire [3:0] over_current,
  input wire [2:0] chip_mode,
  input wire [3:0] high_side_output
);
  // ----------------
  // checks
  // ----------------
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  AST_RST_IDLE:
    assert property ($rose(aresetn) |-> high_side_output == 4'h0 && !s_axi_bvalid)
    else $error("block not idle after reset");
  AST_AW_PULSE:
    assert property (s_axi_awready |=> !s_axi_awready) else $error("awready held");
  AST_B_HOLD:
    assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid) else $error("bvalid lost");
  AST_R_HOLD:
    assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid) else $error("rvalid lost");
  AST_R_ANSWER:
    assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("no rvalid");
  AST_RESTART_OFF:
    assert property ((chip_mode == 3'h3) [*3] |-> high_side_output == 4'h0)
    else $error("output on in restart");
  AST_FAILSAFE_OFF:
    assert property ((chip_mode == 3'h4) [*3] |-> high_side_output == 4'h0)
    else $error("output on in fail-safe");
  // an overcurrent rising on driven channel 0 must not switch it off in the next two cycles
  AST_OC_FILTER:
    assert property ($rose(over_current[0]) && high_side_output[0] && chip_mode == 3'h0
      |=> high_side_output[0] [*2]) else $error("overcurrent trip too early");
endmodule
bind high_side_switch_control hs_switch_monitor mon_u (.aclk(aclk), .aresetn(aresetn),
  .s_axi_awready(s_axi_awready), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .over_current(over_current),
  .chip_mode(chip_mode), .high_side_output(high_side_output));

/* File: tb/load_model.sv */
// behavioural loads on the four high-side outputs
// assumes the bench selects shorted or open channels
`timescale 1ns/10ps
module load_model
(
  // gate drive and fault selection
  input  wire [3:0] high_side_output,
  input  wire [3:0] short_sel,
  input  wire [3:0] open_sel,
  // comparator levels back to the block
  output wire [3:0] over_current,
  output wire [3:0] under_current
);
  // ----------------
  // loads
  // ----------------
  // a channel that is off carries no current, so its low-current comparator reads high
  assign over_current  = high_side_output & short_sel;
  assign under_current = ~high_side_output | open_sel;
endmodule

/* File: tb/tb_high_side_switch_control.sv */
// self-checking bench for the high-side switch block
// assumes the load model on the outputs and a 25 MHz clock
`timescale 1ns/10ps
`include "hs_switch_defs.vh"
`define A(o) {o, 2'b00}
`define CHK(x, y) begin n_tests = n_tests + 1; if ((x) !== (y)) begin errors = errors + 1; \
  $display("wrong value at %0t: %h %h", $time, x, y); end end
module tb_high_side_switch_control;
  reg         aclk, aresetn, awv, wv, br, arv, rr, ov, uv, t1, t2;
  reg  [5:0]  awa, ara;
  reg  [31:0] wd, rd;
  reg  [2:0]  mode;
  reg  [3:0]  shrt, opn;
  reg  [1:0]  rs;
  reg  [7:0]  d;
  wire        awr, wrd, bv, arr, rv;
  wire [1:0]  bres, rres;
  wire [31:0] rdat;
  wire [3:0]  oc, uc, hs;
  integer     errors, n_tests, i, n;
  high_side_switch_control #(.OC_CYC(4), .OL_CYC(4)) dut_u (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd),
    .s_axi_wstrb(4'hF), .s_axi_wvalid(wv), .s_axi_wready(wrd), .s_axi_bresp(bres),
    .s_axi_bvalid(bv), .s_axi_bready(br), .s_axi_araddr(ara), .s_axi_arvalid(arv),
    .s_axi_arready(arr), .s_axi_rdata(rdat), .s_axi_rresp(rres), .s_axi_rvalid(rv),
    .s_axi_rready(rr), .supply_ov(ov), .supply_uv(uv), .over_current(oc),
    .under_current(uc), .chip_mode(mode), .timer1_out(t1), .timer2_out(t2),
    .high_side_output(hs));
  load_model load_u (.high_side_output(hs), .short_sel(shrt), .open_sel(opn),
    .over_current(oc), .under_current(uc));
  // ----------------
  // helpers
  // ----------------
  function exp_out(input [2:0] c, input a, input b);
    exp_out = (c == `SRC_ON) | (c == `SRC_TMR1 & a) | (c == `SRC_TMR2 & b);
  endfunction
  task tick(input integer k);
    repeat (k) @(posedge aclk);
  endtask
  task wr(input [5:0] a, input [31:0] v);
    begin
      @(posedge aclk);
      {awa, wd, awv, wv, br} <= {a, v, 3'b111};
      do
      begin
        @(posedge aclk);
        if (awr) awv <= 1'b0;
        if (wrd) wv <= 1'b0;
      end
      while (bv !== 1'b1);
      rs = bres;
      br <= 1'b0;
    end
  endtask
  task rdr(input [5:0] a);
    begin
      @(posedge aclk);
      {ara, arv, rr} <= {a, 2'b11};
      do
      begin
        @(posedge aclk);
        if (arr) arv <= 1'b0;
      end
      while (rv !== 1'b1);
      {rs, rd} = {rres, rdat};
      rr <= 1'b0;
    end
  endtask
  task rc(input [5:0] a, input [31:0] e);
    begin
      rdr(a);
      `CHK({rs, rd}, {`RESP_OKAY, e})
    end
  endtask
  task give_verdict;
    begin
      if (errors == 0 && n_tests > 0)
        $display("Testbench passed");
      else
        $display("Testbench failed");
      $finish;
    end
  endtask
  // ----------------
  // stimulus
  // ----------------
  initial
  begin
    aclk = 1'b0;
    forever #20 aclk = ~aclk;
  end
  initial
  begin
    #3800000;
    errors = errors + 1;
    give_verdict;
  end
  initial
  begin
    {aresetn, awv, wv, br, arv, rr, ov, uv, t1, t2} = 10'h000;
    {awa, ara, wd, mode, shrt, opn, d} = 63'h0;
    errors = 0;
    n_tests = 0;
    i = $urandom(32'hEB41);
    tick(12);
    aresetn <= 1'b1;
    for (i = 0; i < 10; i = i + 1)
      rc(`A(i[3:0]), 0);
    for (i = 0; i < 16; i = i + 1)
    begin
      {t1, t2} <= 2'($urandom);
      wr(`A(`OFS_CTRL_A), i % 4);
      tick(3);
      `CHK(hs[0], exp_out(i % 4, t1, t2))
    end
    wr(`A(`OFS_CTRL_B), {`SRC_TMR2, `SRC_ON});
    tick(3);
    `CHK(hs[3:2], {t2, 1'b1})
    d = 8'(3 + $urandom % 30);
    wr(`A(`OFS_DUTY_A), d);
    wr(`A(`OFS_FREQ), 1);
    wr(`A(`OFS_CTRL_A), {`SRC_PWM2, `SRC_PWM1});
    while (hs[0] === 1'b1) tick(1);
    while (hs[0] !== 1'b1) tick(1);
    for (n = 0; hs[0] === 1'b1; n = n + 1)
    begin
      tick(1);
      `CHK(hs[1], 1'b0)
    end
    `CHK(n + 1 >= d * `PWM_STEP_FAST && n <= d * `PWM_STEP_FAST + 1, 1'b1)
    wr(`A(`OFS_CTRL_A), `SRC_ON);
    tick(2);
    shrt <= 4'h1;
    tick(2);
    `CHK(hs[0], 1'b1)
    tick(6);
    `CHK(hs[0], 1'b0)
    shrt <= 4'h0;
    rc(`A(`OFS_CTRL_A), `SRC_OFF);
    tick(20);
    rc(`A(`OFS_OC_STAT), 1);
    wr(`A(`OFS_OC_STAT), 1);
    rc(`A(`OFS_OC_STAT), 0);
    wr(`A(`OFS_CTRL_A), `SRC_ON);
    opn <= 4'h1;
    tick(10);
    `CHK(hs[0], 1'b1)
    opn <= 4'h0;
    tick(10);
    rc(`A(`OFS_OL_STAT), 1);
    wr(`A(`OFS_OL_STAT), 1);
    rc(`A(`OFS_OL_STAT), 0);
    for (i = 0; i < 4; i = i + 1)
    begin
      n = 4 + (i > 1) * (1 + i % 2);
      wr(`A(`OFS_SUPPLY_CFG), n);
      {uv, ov} <= 2'b01 << i % 2;
      tick(3);
      `CHK(hs[0], n[i % 2])
      rc(`A(`OFS_SUPPLY_STAT), 1 << i % 2);
      {uv, ov} <= 2'b00;
      tick(3);
      `CHK(hs[0], 1'b1)
    end
    rc(`A(`OFS_OC_STAT), 0);
    wr(`A(`OFS_SUPPLY_CFG), 0);
    uv <= 1'b1;
    tick(3);
    uv <= 1'b0;
    tick(3);
    `CHK(hs[0], 1'b0)
    rc(`A(`OFS_CTRL_A), 0);
    wr(`A(`OFS_CTRL_A), `SRC_ON);
    for (i = 1; i < 3; i = i + 1)
    begin
      mode <= i;
      wr(`A(`OFS_CTRL_A), `SRC_OFF);
      `CHK(rs, `RESP_OKAY)
      tick(2);
      `CHK(hs[0], 1'b1)
      rc(`A(`OFS_CTRL_A), `SRC_ON);
    end
    shrt <= 4'h1;
    tick(10);
    `CHK(hs[0], 1'b0)
    {shrt, mode} <= {4'h0, `MODE_NORMAL};
    wr(`A(`OFS_CTRL_A), `SRC_ON);
    for (i = 3; i < 5; i = i + 1)
    begin
      mode <= i;
      tick(4);
      `CHK(hs[0], 1'b0)
    end
    mode <= `MODE_NORMAL;
    wr(`A(`OFS_CTRL_A), `SRC_ON);
    tick(3);
    `CHK(hs[0], 1'b1)
    rdr(`A(4'hA));
    `CHK({rs, rd}, {`RESP_SLVERR, 32'h0})
    wr(`A(`OFS_SUPPLY_STAT), 3);
    `CHK(rs, `RESP_SLVERR)
    give_verdict;
  end
endmodule
